// ===== hdl/ddrrp_user_read_path.v
/*
 * Read path of a DDR controller user interface: shared command queue,
 * row/bank management, refresh, latency calibration, read buffer.
 * Assumes a PHY that captures DQ into rise/fall words and flags the
 * calibration read's arrival; one user clock drives all logic.
 */
// Operation
// - One queue carries both reads and writes
// - Read buffer built from 16x1 bit cells
// - Pop entry, decode opcode, issue memory read or write
// - Measure round trip, time buffer writes
// - Capture timing follows measured round trip, never below CAS latency
// - Valid marks each cycle with read word
// - Open-row read timing chain from queue
// - Row conflict: precharge, activate, then read
// - Conflict spacing: PRE, 3 ACT, 4 READ
// - Open-row hit skips activation
// - Periodic refresh closes all open rows
// - Memory commands launched from rising-edge flops
// - Read outputs come from final register stage
// - Entry holds 32-bit address, 4-bit opcode
`timescale 1ns/1ps
`default_nettype none
`include "ddrrp_regs.vh"

module ddrrp_user_read_path (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire cmd_queue_write_enable_in,
    input wire [31:0] cmd_queue_address_in,
    input wire [3:0] cmd_queue_opcode_in,
    input wire [2:0] cas_latency_in,
    input wire [7:0] mem_rise_data_in,
    input wire [7:0] mem_fall_data_in,
    input wire mem_data_arrive_in,
    output reg cmd_queue_full_flag_out,
    output reg cmd_queue_empty_out,
    output reg calib_done_out,
    output reg [2:0] mem_cmd_out,
    output reg [1:0] mem_bank_out,
    output reg [12:0] mem_addr_out,
    output wire [15:0] rd_data_out,
    output reg rd_valid_out
);

    localparam [9:0] S_CAL = 10'h001;
    localparam [9:0] S_CALW = 10'h002;
    localparam [9:0] S_IDLE = 10'h004;
    localparam [9:0] S_DEC = 10'h008;
    localparam [9:0] S_PRE = 10'h010;
    localparam [9:0] S_ACT = 10'h020;
    localparam [9:0] S_RPRE = 10'h040;
    localparam [9:0] S_REF = 10'h080;
    localparam [9:0] S_CALA = 10'h100;
    localparam [9:0] S_HOLD = 10'h200;
    localparam integer REF_LAST_I = `DDRRP_REF_INT_CYC - 1;
    localparam integer RFC_LAST_I = `DDRRP_RFC_CYC - 1;
    localparam [9:0] REF_LAST = REF_LAST_I[9:0];
    localparam [4:0] RFC_LAST = RFC_LAST_I[4:0];

    reg [9:0] state_r;
    reg [4:0] cnt_r;
    reg [4:0] cq_wp_r;
    reg [4:0] cq_rp_r;
    reg [19:0] cq_vis_r;
    reg [35:0] ent_r;
    reg [3:0] bank_open_r;
    reg [51:0] row_tab_r;
    reg [2:0] cl_r;
    reg [4:0] cap_idx_r;
    reg [33:0] cap_sr_r;
    reg [4:0] rb_wp_r;
    reg [4:0] rb_rp_r;
    reg [9:0] ref_cnt_r;
    reg ref_pend_r;
    wire [35:0] cq_q;
    wire cq_push;
    wire cq_pop;
    wire [4:0] cq_wp_nxt;
    wire [4:0] cq_rp_nxt;
    wire [4:0] cq_lvl;
    wire [1:0] ent_bank;
    wire [12:0] ent_row;
    wire [12:0] ent_col;
    wire ent_rd;
    wire ent_wr;
    wire [2:0] ent_cmd;
    wire row_hit;
    wire cap_we;
    wire rb_pop;
    wire ref_due;

    // ============================================================
    // Command queue: one ordered stream for reads and writes
    // Full is flagged one entry early so a registered flag never
    // lets a push through into a full queue
    assign cq_push = cmd_queue_write_enable_in & ~cmd_queue_full_flag_out;
    assign cq_pop = state_r[2] & ~cmd_queue_empty_out & ~ref_pend_r;
    assign cq_wp_nxt = cq_wp_r + {4'h0, cq_push};
    assign cq_rp_nxt = cq_rp_r + {4'h0, cq_pop};
    assign cq_lvl = cq_wp_nxt - cq_rp_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < `DDRRP_CQ_W; gi = gi + 1) begin : g_cq
            ddrrp_bit_ram u_cell (
                .clk_in(ref_clk_in),
                .we_in(cq_push),
                .wa_in(cq_wp_r[3:0]),
                .d_in(gi < 32 ? cmd_queue_address_in[gi % 32] :
                      cmd_queue_opcode_in[gi % 4]),
                .ra_in(cq_rp_r[3:0]),
                .q_out(cq_q[gi])
            );
        end
    endgenerate

    // Write pointer reaches the empty flag through a short pipe, so
    // a push shows as not-empty five clocks later
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            cq_wp_r <= 5'h00;
            cq_rp_r <= 5'h00;
            cq_vis_r <= 20'h00000;
            cmd_queue_full_flag_out <= 1'b0;
            cmd_queue_empty_out <= 1'b1;
        end else begin
            cq_wp_r <= cq_wp_nxt;
            cq_rp_r <= cq_rp_nxt;
            cq_vis_r <= {cq_vis_r[14:0], cq_wp_r};
            cmd_queue_full_flag_out <= (cq_lvl >= `DDRRP_CQ_FULL_LVL);
            cmd_queue_empty_out <= (cq_vis_r[19:15] == cq_rp_nxt);
        end
    end

    // ============================================================
    // Entry decode and open-row lookup
    assign ent_bank = ent_r[`DDRRP_BANK_LSB +: `DDRRP_BANK_W];
    assign ent_row = ent_r[`DDRRP_ROW_LSB +: `DDRRP_ROW_W];
    assign ent_col = {3'h0, ent_r[`DDRRP_COL_LSB +: `DDRRP_COL_W]};
    assign ent_rd = (ent_r[34:32] == `DDRRP_OP_READ);
    assign ent_wr = (ent_r[34:32] == `DDRRP_OP_WRITE);
    assign ent_cmd = ent_rd ? `DDRRP_MC_RD : `DDRRP_MC_WR;
    assign row_hit = bank_open_r[ent_bank] &
                     (row_tab_r[ent_bank * 13 +: 13] == ent_row);

    // ============================================================
    // Refresh timer; a due refresh is taken ahead of queued entries
    assign ref_due = (ref_cnt_r == REF_LAST);
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            ref_cnt_r <= 10'h000;
            ref_pend_r <= 1'b0;
        end else begin
            ref_cnt_r <= ref_due ? 10'h000 : ref_cnt_r + 10'h001;
            // A new due tick wins over the clear on take-up
            ref_pend_r <= ref_due | (ref_pend_r & ~state_r[2]);
        end
    end

    // ============================================================
    // Sequencer: calibration, then decode, row management, refresh.
    // Commands leave a rising-edge flop here and drive the memory
    // pins directly, giving whole-cycle offsets
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state_r <= S_CAL;
            cnt_r <= 5'h00;
            ent_r <= 36'h0;
            bank_open_r <= 4'h0;
            row_tab_r <= 52'h0;
            cl_r <= cas_latency_in;
            cap_idx_r <= 5'h00;
            calib_done_out <= 1'b0;
            mem_cmd_out <= `DDRRP_MC_NOP;
            mem_bank_out <= 2'h0;
            mem_addr_out <= 13'h0000;
        end else begin
            mem_cmd_out <= `DDRRP_MC_NOP;
            cnt_r <= cnt_r + 5'h01;
            case (state_r)
                S_CAL: begin
                    // Open bank 0 row 0 for the training read
                    mem_cmd_out <= `DDRRP_MC_ACT;
                    mem_bank_out <= 2'h0;
                    mem_addr_out <= 13'h0000;
                    cnt_r <= 5'h00;
                    state_r <= S_CALA;
                end
                S_CALA: begin
                    if (cnt_r == `DDRRP_ACT_TO_RD_CYC - 5'h01) begin
                        mem_cmd_out <= `DDRRP_MC_RD;
                        cnt_r <= 5'h00;
                        state_r <= S_CALW;
                    end
                end
                S_CALW: begin
                    // Round trip counted from READ on the bus
                    if (mem_data_arrive_in ||
                        cnt_r == `DDRRP_CAL_TIMEOUT) begin
                        // Extra delay above CL, never below CL itself
                        cap_idx_r <= (cnt_r > {2'h0, cl_r}) ?
                                     cnt_r - 5'h01 :
                                     {2'h0, cl_r} - 5'h01;
                        bank_open_r <= 4'h1;
                        row_tab_r <= 52'h0;
                        calib_done_out <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (ref_pend_r) begin
                        // Close every row before refreshing
                        mem_cmd_out <= `DDRRP_MC_PRE;
                        mem_addr_out <= `DDRRP_PRE_ALL_ADDR;
                        bank_open_r <= 4'h0;
                        cnt_r <= 5'h00;
                        state_r <= S_RPRE;
                    end else if (cq_pop) begin
                        state_r <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    ent_r <= cq_q;
                    cnt_r <= 5'h00;
                    state_r <= S_DEC;
                end
                S_DEC: begin
                    // One spare beat puts the first command 4 clocks
                    // after the empty flag falls; a dropped entry
                    // leaves bank and address untouched
                    if (cnt_r == `DDRRP_DEC_WAIT_CYC) begin
                        cnt_r <= 5'h00;
                        if (ent_rd || ent_wr) begin
                            mem_bank_out <= ent_bank;
                        end
                        if (!ent_rd && !ent_wr) begin
                            state_r <= S_IDLE;
                        end else if (row_hit) begin
                            mem_cmd_out <= ent_cmd;
                            mem_addr_out <= ent_col;
                            state_r <= S_IDLE;
                        end else if (bank_open_r[ent_bank]) begin
                            mem_cmd_out <= `DDRRP_MC_PRE;
                            mem_addr_out <= 13'h0000;
                            state_r <= S_PRE;
                        end else begin
                            mem_cmd_out <= `DDRRP_MC_ACT;
                            mem_addr_out <= ent_row;
                            state_r <= S_ACT;
                        end
                    end
                end
                S_PRE: begin
                    if (cnt_r == `DDRRP_PRE_TO_ACT_CYC - 5'h01) begin
                        mem_cmd_out <= `DDRRP_MC_ACT;
                        mem_addr_out <= ent_row;
                        cnt_r <= 5'h00;
                        state_r <= S_ACT;
                    end
                end
                S_ACT: begin
                    if (cnt_r == `DDRRP_ACT_TO_RD_CYC - 5'h01) begin
                        mem_cmd_out <= ent_cmd;
                        mem_addr_out <= ent_col;
                        bank_open_r[ent_bank] <= 1'b1;
                        row_tab_r[ent_bank * 13 +: 13] <= ent_row;
                        state_r <= S_IDLE;
                    end
                end
                S_RPRE: begin
                    if (cnt_r == `DDRRP_PRE_TO_ACT_CYC - 5'h01) begin
                        mem_cmd_out <= `DDRRP_MC_REF;
                        cnt_r <= 5'h00;
                        state_r <= S_REF;
                    end
                end
                S_REF: begin
                    if (cnt_r == RFC_LAST) begin
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_CAL;
                end
            endcase
        end
    end

    // ============================================================
    // Capture timing: a token per user READ walks a shift line and
    // opens two write beats (burst of four) at the calibrated tap
    assign cap_we = cap_sr_r[cap_idx_r] | cap_sr_r[cap_idx_r + 5'h01];
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            cap_sr_r <= 34'h0;
        end else begin
            cap_sr_r <= {cap_sr_r[32:0],
                         calib_done_out &
                         (mem_cmd_out == `DDRRP_MC_RD)};
        end
    end

    // ============================================================
    // Read buffer: one 16x1 cell per rise bit and per fall bit.
    // It drains one word a cycle as fast as it fills, so with at
    // most two beats per read it cannot overflow
    generate
        for (gi = 0; gi < 2 * `DDRRP_DW; gi = gi + 1) begin : g_rb
            ddrrp_bit_ram u_cell (
                .clk_in(ref_clk_in),
                .we_in(cap_we),
                .wa_in(rb_wp_r[3:0]),
                .d_in(gi < 8 ? mem_rise_data_in[gi % 8] :
                      mem_fall_data_in[gi % 8]),
                .ra_in(rb_rp_r[3:0]),
                .q_out(rd_data_out[gi])
            );
        end
    endgenerate

    assign rb_pop = (rb_wp_r != rb_rp_r);

    // Word and valid leave from registers in the same cycle, in order
    always @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            rb_wp_r <= 5'h00;
            rb_rp_r <= 5'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rb_wp_r <= rb_wp_r + {4'h0, cap_we};
            rb_rp_r <= rb_rp_r + {4'h0, rb_pop};
            rd_valid_out <= rb_pop;
        end
    end

endmodule

`default_nettype wire

// ===== hdl/ddrrp_regs.vh
/*
 * Constants of the user read path: queue layout, address fields,
 * memory command codes and timing counts.
 * Assumes a 125 MHz user clock and a DDR part with 4 banks.
 */
`ifndef DDRRP_REGS_VH
`define DDRRP_REGS_VH

// ============================================================
// Widths and queue layout
`define DDRRP_DW 8
`define DDRRP_ADDR_W 32
`define DDRRP_OP_W 4
`define DDRRP_CQ_W 36
`define DDRRP_CQ_FULL_LVL 5'h0f
`define DDRRP_CQ_VIS_W 20

// ============================================================
// Opcodes on the queue
`define DDRRP_OP_WRITE 3'h0
`define DDRRP_OP_READ 3'h1

// ============================================================
// Address fields of a queue entry
`define DDRRP_COL_LSB 0
`define DDRRP_COL_W 10
`define DDRRP_ROW_LSB 10
`define DDRRP_ROW_W 13
`define DDRRP_BANK_LSB 23
`define DDRRP_BANK_W 2
`define DDRRP_PRE_ALL_ADDR 13'h0400

// ============================================================
// Memory commands as {ras_n, cas_n, we_n}
`define DDRRP_MC_NOP 3'h7
`define DDRRP_MC_ACT 3'h3
`define DDRRP_MC_RD 3'h5
`define DDRRP_MC_WR 3'h4
`define DDRRP_MC_PRE 3'h2
`define DDRRP_MC_REF 3'h1

// ============================================================
// Timing
`define DDRRP_CLK_PERIOD_NS 8
`define DDRRP_PRE_TO_ACT_CYC 5'h03
`define DDRRP_ACT_TO_RD_CYC 5'h04
`define DDRRP_DEC_WAIT_CYC 5'h01
`define DDRRP_REF_INT_NS 7800
`define DDRRP_REF_INT_CYC (`DDRRP_REF_INT_NS / `DDRRP_CLK_PERIOD_NS)
`define DDRRP_RFC_NS 75
`define DDRRP_RFC_CYC ((`DDRRP_RFC_NS + `DDRRP_CLK_PERIOD_NS - 1) / `DDRRP_CLK_PERIOD_NS)
`define DDRRP_CAL_TIMEOUT 5'h1f

`endif

// ===== hdl/ddrrp_bit_ram.v
/*
 * One 16-entry, single-bit dual-port RAM cell with a registered read.
 * Assumes write and read addresses are synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module ddrrp_bit_ram (
    input wire clk_in,
    input wire we_in,
    input wire [3:0] wa_in,
    input wire d_in,
    input wire [3:0] ra_in,
    output reg q_out
);

    reg [15:0] mem_r;

    // ============================================================
    // Storage and registered read port
    // Reset is left out on purpose; contents are valid once written
    always @(posedge clk_in) begin
        if (we_in) begin
            mem_r[wa_in] <= d_in;
        end
        q_out <= mem_r[ra_in];
    end

endmodule

`default_nettype wire

// ===== test/ddrrp_mem_model.sv
/*
 * Memory and capture stage behind the read path.
 * Assumes a read on the command bus returns two beats LAT cycles later.
 */
`timescale 1ns/1ps
`default_nettype none

module ddrrp_mem_model #(
    parameter int LAT = 5
) (
    input wire logic clk_in,
    input wire logic [2:0] mem_cmd_in,
    input wire logic [12:0] mem_addr_in,
    output logic [7:0] rise_out,
    output logic [7:0] fall_out,
    output logic arrive_out
);
    // ============================================================
    // Read pipeline, one slot per cycle
    logic [15:0] vld_r = 16'h0;
    logic [6:0] col_r [16];
    logic tgl_r = 1'b0;
    logic seen_r = 1'b0;

    // Column rides along with each read so the data names its source
    always @(posedge clk_in) begin
        vld_r <= {vld_r[14:0], mem_cmd_in == 3'h5};
        col_r[0] <= mem_addr_in[6:0];
        for (int i = 1; i < 16; i++) col_r[i] <= col_r[i - 1];
        tgl_r <= ~tgl_r;
        if (arrive_out) seen_r <= 1'b1;
    end

    // ============================================================
    // Idle bus toggles so that a stale capture never matches
    always @* begin
        if (vld_r[LAT - 1]) rise_out = {col_r[LAT - 1], 1'b0};
        else if (vld_r[LAT]) rise_out = {col_r[LAT], 1'b1};
        else rise_out = {8{tgl_r}} ^ 8'h5a;
        fall_out = ~rise_out;
        arrive_out = vld_r[LAT - 1] & ~seen_r; // Calibration read only
    end
endmodule
`default_nettype wire

// ===== test/ddrrp_checker.sv
/*
 * Port checker of the read path.
 * Assumes the partner answers a read 5 cycles after the command.
 */
`timescale 1ns/1ps
`default_nettype none

module ddrrp_checker (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic cmd_queue_write_enable_in,
    input wire logic cmd_queue_full_flag_out,
    input wire logic cmd_queue_empty_out,
    input wire logic calib_done_out,
    input wire logic [2:0] mem_cmd_out,
    input wire logic [1:0] mem_bank_out,
    input wire logic [12:0] mem_addr_out,
    input wire logic rd_valid_out
);
    // Partner latency plus the two output stages
    localparam int RD_TO_VALID = 7;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // ============================================================
    // Sequences
    sequence quiet_push;
        !cmd_queue_write_enable_in [*5] ##1 (cmd_queue_write_enable_in &&
            !cmd_queue_full_flag_out && cmd_queue_empty_out && calib_done_out);
    endsequence
    sequence pre_act;
        mem_cmd_out == 3'h7 [*2] ##1 mem_cmd_out == 3'h3;
    endsequence
    sequence act_rd;
        mem_cmd_out == 3'h7 [*3] ##1 mem_cmd_out == 3'h5;
    endsequence

    // ============================================================
    // Assertions
    rst_vals_a: assert property (disable iff (1'b0)
        !reset_n_in |=> cmd_queue_empty_out && !calib_done_out &&
        !rd_valid_out && mem_cmd_out == 3'h7 && !cmd_queue_full_flag_out)
        else $error("reset state wrong");
    empty_fall_a: assert property (
        quiet_push |-> ##1 cmd_queue_empty_out [*5] ##1 !cmd_queue_empty_out)
        else $error("empty flag timing wrong");
    conflict_seq_a: assert property (
        (mem_cmd_out == 3'h2 && mem_addr_out != 13'h0400)
        |=> pre_act ##1 act_rd) else $error("conflict order wrong");
    act_rd_a: assert property (mem_cmd_out == 3'h3 |=> act_rd)
        else $error("activate to read wrong");
    refresh_seq_a: assert property (
        (mem_cmd_out == 3'h2 && mem_addr_out == 13'h0400)
        |-> ##3 mem_cmd_out == 3'h1) else $error("refresh order wrong");
    rd_valid_a: assert property (
        (mem_cmd_out == 3'h5 && calib_done_out)
        |-> ##RD_TO_VALID rd_valid_out ##1 rd_valid_out)
        else $error("read valid timing wrong");
    valid_calib_a: assert property (rd_valid_out |-> calib_done_out)
        else $error("valid before calibration");
    addr_hold_a: assert property (mem_cmd_out == 3'h7 |->
        $stable(mem_addr_out) && $stable(mem_bank_out))
        else $error("address moved during idle");
endmodule
`default_nettype wire

// ===== test/ddr_user_read_path_tb.sv
/*
 * Testbench of the read path: reads hit, conflict, closed bank, refresh.
 * Assumes the memory model and checker files are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end

module ddr_user_read_path_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wren = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [3:0] opc = 4'h0;
    logic [7:0] rise, fall;
    logic arrive, full, empty, calib, rd_valid;
    logic [2:0] mem_cmd;
    logic [1:0] bank;
    logic [12:0] maddr;
    logic [15:0] rd_data;
    integer errors = 0;
    integer comparisons = 0;
    integer cycles = 0;
    logic [15:0] got_q [$];
    int n;

    initial begin
        forever #4 clk = ~clk;
    end

    ddrrp_mem_model #(.LAT(5)) u_mem (.clk_in(clk), .mem_cmd_in(mem_cmd),
        .mem_addr_in(maddr), .rise_out(rise), .fall_out(fall),
        .arrive_out(arrive));

    ddrrp_user_read_path u_dut (.ref_clk_in(clk), .reset_n_in(rst_n),
        .cmd_queue_write_enable_in(wren), .cmd_queue_address_in(addr),
        .cmd_queue_opcode_in(opc), .cas_latency_in(3'h3),
        .mem_rise_data_in(rise), .mem_fall_data_in(fall),
        .mem_data_arrive_in(arrive), .cmd_queue_full_flag_out(full),
        .cmd_queue_empty_out(empty), .calib_done_out(calib),
        .mem_cmd_out(mem_cmd), .mem_bank_out(bank), .mem_addr_out(maddr),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid));

    // Collect words and cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rd_valid === 1'b1) got_q.push_back(rd_data);
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    // ============================================================
    // Shared tasks
    task wrap_up;
        if (errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    function automatic [31:0] mk(input [1:0] b, input [12:0] r,
        input [9:0] c);
        mk = {7'h0, b, r, c};
    endfunction

    task push(input [31:0] a, input [3:0] op);
        @(posedge clk);
        `CHK(full, 1'b0)
        wren <= 1'b1;
        addr <= a;
        opc <= op;
        @(posedge clk);
        wren <= 1'b0;
    endtask

    // Next command that is not a NOP must be c
    task next_cmd(input [2:0] c, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (mem_cmd === 3'h7 && n < lim);
        `CHK(mem_cmd, c)
    endtask

    task words(input [6:0] col);
        logic [7:0] r;
        logic [15:0] w;
        for (int k = 0; k < 2; k++) begin
            r = {col, k[0]};
            repeat (60) if (got_q.size() == 0) @(posedge clk);
            if (got_q.size() > 0) begin
                // Pop once, so a mismatch report cannot eat a word
                w = got_q.pop_front();
                `CHK(w, {~r, r})
            end else `CHK(1'b0, 1'b1)
        end
    endtask

    // ============================================================
    // Scenarios
    task t_hit; // Row left open by calibration
        push(mk(2'h0, 13'h0, 10'h011), 4'h1);
        repeat (4) @(posedge clk);
        #1 `CHK(empty, 1'b1)
        @(posedge clk);
        #1 `CHK(empty, 1'b0)
        next_cmd(3'h5, 40);
        `CHK(n, 4)
        `CHK(maddr, 13'h011)
        words(7'h11);
    endtask

    task t_conflict;
        push(mk(2'h0, 13'h5, 10'h022), 4'h1);
        next_cmd(3'h2, 40);
        `CHK(bank, 2'h0)
        next_cmd(3'h3, 9);
        `CHK(n, 3)
        `CHK(maddr, 13'h5)
        next_cmd(3'h5, 9);
        `CHK(n, 4)
        words(7'h22);
    endtask

    task t_closed_b2b; // Closed bank, then two reads pushed back to back
        push(mk(2'h1, 13'h7, 10'h001), 4'h1);
        next_cmd(3'h3, 40);
        `CHK(bank, 2'h1)
        words(7'h01);
        @(posedge clk);
        wren <= 1'b1;
        addr <= mk(2'h1, 13'h7, 10'h003);
        @(posedge clk);
        addr <= mk(2'h1, 13'h7, 10'h004);
        @(posedge clk);
        wren <= 1'b0;
        words(7'h03);
        words(7'h04);
    endtask

    task t_ops; // Write shares the queue; unknown opcode is dropped
        push(mk(2'h1, 13'h7, 10'h005), 4'h0);
        next_cmd(3'h4, 40);
        `CHK(maddr, 13'h005)
        push(mk(2'h1, 13'h7, 10'h006), 4'h6);
        next_cmd(3'h7, 20);
        `CHK(got_q.size(), 0)
    endtask

    task t_refresh; // Refresh closes rows, so the open row needs ACT
        next_cmd(3'h2, 1100);
        `CHK(maddr, 13'h0400)
        next_cmd(3'h1, 9);
        `CHK(n, 3)
        repeat (20) @(posedge clk);
        push(mk(2'h1, 13'h7, 10'h009), 4'h1);
        next_cmd(3'h3, 40);
        next_cmd(3'h5, 9);
        words(7'h09);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (300) if (calib !== 1'b1) @(posedge clk);
        `CHK(calib, 1'b1)
        t_hit();
        t_conflict();
        t_closed_b2b();
        t_ops();
        t_refresh();
        wrap_up();
    end
endmodule

bind ddrrp_user_read_path ddrrp_checker u_chk (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .cmd_queue_write_enable_in(cmd_queue_write_enable_in),
    .cmd_queue_full_flag_out(cmd_queue_full_flag_out),
    .cmd_queue_empty_out(cmd_queue_empty_out),
    .calib_done_out(calib_done_out), .mem_cmd_out(mem_cmd_out),
    .mem_bank_out(mem_bank_out), .mem_addr_out(mem_addr_out),
    .rd_valid_out(rd_valid_out));
`default_nettype wire
